// file: src/power_good_clock_ctrl.sv
// Register file, fault latches, flags, power-good pin and software reset
`timescale 1ns/1ns
`default_nettype none
module power_good_clock_ctrl
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Register access port delivered by the serial interface engine
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_en_i,
   input  wire logic       rd_en_i,
   output logic [7:0]      rdata_o,
   // Rail and system status
   input  wire logic [3:0] rail_uv_ok_i,
   input  wire logic [3:0] rail_ov_ok_i,
   input  wire logic       thermal_warning_i,
   input  wire logic       regulators_active_i,
   input  wire logic       ext_clock_present_i,
   // Power-good pin
   output logic            power_good_out_o,
   output logic            power_good_oe_o,
   // Clock source control
   output logic            pll_enable_o,
   output logic            use_ext_clock_o,
   output logic [4:0]      ext_clock_freq_code_o,
   output logic [5:0]      ext_clock_mhz_o,
   // Software reset side effects
   output logic            otp_reload_o,
   output logic            i2c_reset_o,
   output logic            regulators_disable_o
);
   logic [7:0] clock_source;
   logic [7:0] pg_ctrl_one;
   logic [7:0] pg_ctrl_two;
   logic [3:0] rail_fault;
   logic       pg_lost_flag;
   logic       ext_clock_flag;
   logic       reset_flag;
   logic       soft_reset;
   logic       pg_active_q;
   logic [7:0] next_clock_source;
   logic [7:0] next_pg_ctrl_one;
   logic [7:0] next_pg_ctrl_two;
   logic [3:0] next_rail_fault;
   logic       next_pg_lost_flag;
   logic       next_ext_clock_flag;
   logic       next_reset_flag;
   logic       next_soft_reset;
   logic       next_pg_active_q;
   logic [7:0] next_rdata;
   logic       next_pg_out;
   logic       next_pg_oe;
   logic [5:0] next_mhz;
   logic [4:0] next_code;

   logic [3:0] rail_valid;
   logic       pg_active;
   logic       clock_event;
   logic       pg_level;
   logic       wr_fault;
   logic       wr_int_top;
   logic       wr_int_reset;
   logic [3:0] source_enable;
   logic [3:0] fault_clear;

   // Strobe qualified by an exact register address
   function automatic logic reg_hit
   (
      input logic       strobe,
      input logic [7:0] addr,
      input logic [7:0] target
   );
      reg_hit = strobe && (addr == target);
   endfunction : reg_hit

   assign source_enable = pg_ctrl_one[power_good_out_clk_pkg::SOURCE_MSB:0];

   clock_source_select u_clock_select
   (
      .clk_i          (clk_i),
      .rst_i          (rst_i | soft_reset),
      .pll_select_i   (clock_source[power_good_out_clk_pkg::PLL_SELECT_BIT]),
      .ext_present_i  (ext_clock_present_i),
      .pll_enable_o   (pll_enable_o),
      .use_external_o (use_ext_clock_o),
      .clock_event_o  (clock_event)
   );

   power_good_eval u_eval
   (
      .uv_ok_i             (rail_uv_ok_i),
      .ov_ok_i             (rail_ov_ok_i),
      .linear_window_i     (pg_ctrl_one[power_good_out_clk_pkg::LINEAR_WINDOW_BIT]),
      .buck_window_i       (pg_ctrl_one[power_good_out_clk_pkg::BUCK_WINDOW_BIT]),
      .source_enable_i     (source_enable),
      .rail_fault_i        (rail_fault),
      .fault_gating_i      (pg_ctrl_two[power_good_out_clk_pkg::FAULT_GATE_BIT]),
      .thermal_gating_i    (pg_ctrl_two[power_good_out_clk_pkg::THERMAL_GATE_BIT]),
      .thermal_warning_i   (thermal_warning_i),
      .mode_continuous_i   (pg_ctrl_two[power_good_out_clk_pkg::MODE_BIT]),
      .regulators_active_i (regulators_active_i),
      .rail_valid_o        (rail_valid),
      .pg_active_o         (pg_active)
   );

   assign wr_fault     = reg_hit(wr_en_i, addr_i, power_good_out_clk_pkg::ADDR_RAIL_FAULT);
   assign wr_int_top   = reg_hit(wr_en_i, addr_i, power_good_out_clk_pkg::ADDR_INT_TOP);
   assign wr_int_reset = reg_hit(wr_en_i, addr_i, power_good_out_clk_pkg::ADDR_INT_RESET);

   // A write of one clears a fault only while its rail is valid
   assign fault_clear  = {4{wr_fault}} & wdata_i[3:0] & rail_valid;

   // Valid level is high unless the polarity bit inverts it
   assign pg_level = pg_active ^ pg_ctrl_one[power_good_out_clk_pkg::POLARITY_BIT];

   // Control registers and the software reset request
   always_comb
   begin
      next_clock_source   = clock_source;
      next_pg_ctrl_one    = pg_ctrl_one;
      next_pg_ctrl_two    = pg_ctrl_two;
      next_soft_reset     = 1'b0;
      if (soft_reset)
      begin
         // Everything returns to defaults; writes in this cycle are dropped
         next_clock_source   = power_good_out_clk_pkg::CLOCK_SOURCE_RST;
         next_pg_ctrl_one    = power_good_out_clk_pkg::PG_CTRL_ONE_RST;
         next_pg_ctrl_two    = power_good_out_clk_pkg::PG_CTRL_TWO_RST;
      end
      else if (wr_en_i)
      begin
         case (addr_i)
            power_good_out_clk_pkg::ADDR_CLOCK_SOURCE:
               next_clock_source = wdata_i;
            power_good_out_clk_pkg::ADDR_PG_CTRL_ONE:
               next_pg_ctrl_one = wdata_i;
            power_good_out_clk_pkg::ADDR_PG_CTRL_TWO:
               next_pg_ctrl_two = wdata_i;
            power_good_out_clk_pkg::ADDR_SOFT_RESET:
               next_soft_reset = wdata_i[power_good_out_clk_pkg::SOFT_RESET_BIT];
            default:
               next_soft_reset = 1'b0;
         endcase
      end
   end

   // Fault latches and event flags; a set in the same cycle as a clear wins
   always_comb
   begin
      next_pg_active_q    = pg_active;
      // A rail that is monitored and invalid latches again at once
      next_rail_fault     = (rail_fault & ~fault_clear)
                          | (source_enable & ~rail_valid);
      next_pg_lost_flag   = (pg_lost_flag
                          & ~(wr_int_top & wdata_i[power_good_out_clk_pkg::PG_LOST_BIT]))
                          | (pg_active_q & ~pg_active);
      next_ext_clock_flag = (ext_clock_flag
                          & ~(wr_int_top & wdata_i[power_good_out_clk_pkg::EXT_CLOCK_BIT]))
                          | clock_event;
      next_reset_flag     = reset_flag
                          & ~(wr_int_reset & wdata_i[power_good_out_clk_pkg::RESET_FLAG_BIT]);
      if (soft_reset)
      begin
         next_rail_fault     = 4'h0;
         next_pg_lost_flag   = 1'b0;
         next_ext_clock_flag = 1'b0;
         next_pg_active_q    = 1'b0;
         next_reset_flag     = 1'b1;
      end
   end

   // Pin drive and frequency readout
   always_comb
   begin
      if (pg_ctrl_one[power_good_out_clk_pkg::DRIVE_TYPE_BIT])
      begin
         next_pg_out = 1'b0;
         next_pg_oe  = ~pg_level;
      end
      else
      begin
         next_pg_out = pg_level;
         next_pg_oe  = 1'b1;
      end
      if (soft_reset)
      begin
         next_pg_out = 1'b0;
         next_pg_oe  = 1'b0;
      end
      next_code = clock_source[power_good_out_clk_pkg::FREQ_MSB:0];
      next_mhz = power_good_out_clk_pkg::freq_mhz(clock_source[power_good_out_clk_pkg::FREQ_MSB:0]);
   end

   // Read data, registered one cycle after the read strobe
   always_comb
   begin
      next_rdata = rdata_o;
      if (rd_en_i)
      begin
         case (addr_i)
            power_good_out_clk_pkg::ADDR_CLOCK_SOURCE:
               next_rdata = clock_source;
            power_good_out_clk_pkg::ADDR_PG_CTRL_ONE:
               next_rdata = pg_ctrl_one;
            power_good_out_clk_pkg::ADDR_PG_CTRL_TWO:
               next_rdata = pg_ctrl_two;
            power_good_out_clk_pkg::ADDR_RAIL_FAULT:
               next_rdata = {4'h0, rail_fault};
            power_good_out_clk_pkg::ADDR_SOFT_RESET:
               next_rdata = {7'h00, soft_reset};
            power_good_out_clk_pkg::ADDR_INT_TOP:
            begin
               next_rdata = 8'h00;
               next_rdata[power_good_out_clk_pkg::PG_LOST_BIT]   = pg_lost_flag;
               next_rdata[power_good_out_clk_pkg::EXT_CLOCK_BIT] = ext_clock_flag;
            end
            power_good_out_clk_pkg::ADDR_INT_RESET:
               next_rdata = {7'h00, reset_flag};
            default:
               next_rdata = 8'h00;
         endcase
      end
      if (soft_reset)
         next_rdata = 8'h00;
   end

   // Control registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         clock_source <= power_good_out_clk_pkg::CLOCK_SOURCE_RST;
         pg_ctrl_one  <= power_good_out_clk_pkg::PG_CTRL_ONE_RST;
         pg_ctrl_two  <= power_good_out_clk_pkg::PG_CTRL_TWO_RST;
         soft_reset   <= 1'b0;
      end
      else
      begin
         clock_source <= next_clock_source;
         pg_ctrl_one  <= next_pg_ctrl_one;
         pg_ctrl_two  <= next_pg_ctrl_two;
         soft_reset   <= next_soft_reset;
      end
   end

   // Fault latches and flags
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rail_fault     <= 4'h0;
         pg_lost_flag   <= 1'b0;
         ext_clock_flag <= 1'b0;
         reset_flag     <= 1'b0;
         pg_active_q    <= 1'b0;
      end
      else
      begin
         rail_fault     <= next_rail_fault;
         pg_lost_flag   <= next_pg_lost_flag;
         ext_clock_flag <= next_ext_clock_flag;
         reset_flag     <= next_reset_flag;
         pg_active_q    <= next_pg_active_q;
      end
   end

   // Pin and frequency outputs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         power_good_out_o      <= 1'b0;
         power_good_oe_o       <= 1'b0;
         ext_clock_freq_code_o <= power_good_out_clk_pkg::CLOCK_SOURCE_RST[power_good_out_clk_pkg::FREQ_MSB:0];
         ext_clock_mhz_o       <= power_good_out_clk_pkg::freq_mhz(
                                     power_good_out_clk_pkg::CLOCK_SOURCE_RST[power_good_out_clk_pkg::FREQ_MSB:0]);
      end
      else
      begin
         power_good_out_o      <= next_pg_out;
         power_good_oe_o       <= next_pg_oe;
         ext_clock_freq_code_o <= next_code;
         ext_clock_mhz_o       <= next_mhz;
      end
   end

   // Read data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 8'h00;
      end
      else
      begin
         rdata_o <= next_rdata;
      end
   end

   // Side effects of a software reset last exactly the one cycle it is applied
   assign otp_reload_o         = soft_reset;
   assign i2c_reset_o          = soft_reset;
   assign regulators_disable_o = soft_reset;
endmodule : power_good_clock_ctrl
`default_nettype wire

// file: common/power_good_out_clk_pkg.sv
// Constants, types and helpers for the power-good and clock-source control block
// How it works
// - Select bit clear: internal oscillator, PLL off
// - Select bit set: PLL on, external clock preferred
// - External clock appearing or vanishing raises event while select bit set
// - Frequency code means code plus one MHz
// - Polarity bit picks valid output level
// - Drive bit: push-pull or open-drain output
// - Linear window bit: undervoltage only or both
// - Buck window bit: undervoltage only or both
// - Four source bits pick monitored rails
// - Thermal gating forces output inactive on warning
// - Fault gating: live status or latched flags
// - Mode bit: gated or continuous operation
// - Monitored failing rail latches its fault flag
// - Write one clears fault only if valid
// - Software reset restores defaults, reloads, resets interface
// - Software reset bit clears itself afterwards
// - Output falling inactive latches lost flag
// - External clock change latches clock flag while select bit set
// - Software reset sets reset-occurred flag, disables regulators
package power_good_out_clk_pkg;
   localparam logic [7:0] ADDR_CLOCK_SOURCE  = 8'h14;
   localparam logic [7:0] ADDR_PG_CTRL_ONE   = 8'h15;
   localparam logic [7:0] ADDR_PG_CTRL_TWO   = 8'h16;
   localparam logic [7:0] ADDR_RAIL_FAULT    = 8'h17;
   localparam logic [7:0] ADDR_SOFT_RESET    = 8'h18;
   localparam logic [7:0] ADDR_INT_TOP       = 8'h19;
   localparam logic [7:0] ADDR_INT_RESET     = 8'h1a;

   localparam logic [7:0] CLOCK_SOURCE_RST   = 8'h01;
   localparam logic [7:0] PG_CTRL_ONE_RST    = 8'h70;
   localparam logic [7:0] PG_CTRL_TWO_RST    = 8'h01;

   localparam int unsigned PLL_SELECT_BIT    = 6;
   localparam int unsigned FREQ_MSB          = 4;
   localparam int unsigned POLARITY_BIT      = 7;
   localparam int unsigned DRIVE_TYPE_BIT    = 6;
   localparam int unsigned LINEAR_WINDOW_BIT = 5;
   localparam int unsigned BUCK_WINDOW_BIT   = 4;
   localparam int unsigned SOURCE_MSB        = 3;
   localparam int unsigned THERMAL_GATE_BIT  = 2;
   localparam int unsigned FAULT_GATE_BIT    = 1;
   localparam int unsigned MODE_BIT          = 0;
   localparam int unsigned SOFT_RESET_BIT    = 0;
   localparam int unsigned PG_LOST_BIT       = 7;
   localparam int unsigned EXT_CLOCK_BIT     = 4;
   localparam int unsigned RESET_FLAG_BIT    = 0;

   typedef enum logic [1:0]
   {
      CLK_INTERNAL = 2'b00,
      CLK_PLL_WAIT = 2'b01,
      CLK_EXTERNAL = 2'b10
   } clock_state_t;

   // Frequency in MHz of a code; codes above 0x17 are not to be used
   function automatic logic [5:0] freq_mhz(input logic [4:0] code);
      freq_mhz = {1'b0, code} + 6'h01;
   endfunction : freq_mhz
endpackage : power_good_out_clk_pkg

// file: src/clock_source_select.sv
// Choice between internal oscillator and external clock through the PLL
`timescale 1ns/1ns
`default_nettype none
module clock_source_select
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pll_select_i,
   input  wire logic ext_present_i,
   output logic      pll_enable_o,
   output logic      use_external_o,
   output logic      clock_event_o
);
   power_good_out_clk_pkg::clock_state_t state;
   power_good_out_clk_pkg::clock_state_t next_state;
   logic                        next_event;

   always_comb
   begin
      next_state = state;
      next_event = 1'b0;
      case (state)
         power_good_out_clk_pkg::CLK_INTERNAL:
            if (pll_select_i)
               next_state = power_good_out_clk_pkg::CLK_PLL_WAIT;
         power_good_out_clk_pkg::CLK_PLL_WAIT:
            if (!pll_select_i)
               next_state = power_good_out_clk_pkg::CLK_INTERNAL;
            else if (ext_present_i)
            begin
               next_state = power_good_out_clk_pkg::CLK_EXTERNAL;
               next_event = 1'b1;
            end
         power_good_out_clk_pkg::CLK_EXTERNAL:
            if (!pll_select_i)
               next_state = power_good_out_clk_pkg::CLK_INTERNAL;
            else if (!ext_present_i)
            begin
               next_state = power_good_out_clk_pkg::CLK_PLL_WAIT;
               next_event = 1'b1;
            end
         default:
            next_state = power_good_out_clk_pkg::CLK_INTERNAL;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state         <= power_good_out_clk_pkg::CLK_INTERNAL;
         clock_event_o <= 1'b0;
      end
      else
      begin
         state         <= next_state;
         clock_event_o <= next_event;
      end
   end

   assign pll_enable_o   = (state != power_good_out_clk_pkg::CLK_INTERNAL);
   assign use_external_o = (state == power_good_out_clk_pkg::CLK_EXTERNAL);
endmodule : clock_source_select
`default_nettype wire

// file: src/power_good_eval.sv
// Combinational evaluation of rail validity and the power-good condition
`timescale 1ns/1ns
`default_nettype none
module power_good_eval
(
   input  wire logic [3:0] uv_ok_i,
   input  wire logic [3:0] ov_ok_i,
   input  wire logic       linear_window_i,
   input  wire logic       buck_window_i,
   input  wire logic [3:0] source_enable_i,
   input  wire logic [3:0] rail_fault_i,
   input  wire logic       fault_gating_i,
   input  wire logic       thermal_gating_i,
   input  wire logic       thermal_warning_i,
   input  wire logic       mode_continuous_i,
   input  wire logic       regulators_active_i,
   output logic [3:0]      rail_valid_o,
   output logic            pg_active_o
);
   logic live_ok;
   logic fault_ok;

   always_comb
   begin
      // Bits 3..2 linear regulators, 1..0 bucks
      rail_valid_o[3:2] = uv_ok_i[3:2] & (ov_ok_i[3:2] | {2{~linear_window_i}});
      rail_valid_o[1:0] = uv_ok_i[1:0] & (ov_ok_i[1:0] | {2{~buck_window_i}});
      live_ok     = &(rail_valid_o | ~source_enable_i);
      fault_ok    = ~|rail_fault_i;
      pg_active_o = fault_gating_i ? fault_ok : live_ok;
      if (thermal_gating_i && thermal_warning_i)
         pg_active_o = 1'b0;
      if (!mode_continuous_i && !regulators_active_i)
         pg_active_o = 1'b0;
   end
endmodule : power_good_eval
`default_nettype wire

// file: testbench/rail_status_model.sv
// Supervisory model: rail comparators, thermal sensor and clock detector
`timescale 1ns/1ns
`default_nettype none
module rail_status_model
(
   input  wire logic [3:0] uv_fail_i,
   input  wire logic [3:0] ov_fail_i,
   input  wire logic       hot_i,
   input  wire logic       on_i,
   input  wire logic       ext_i,
   output logic [3:0]      uv_ok_o,
   output logic [3:0]      ov_ok_o,
   output logic            warn_o,
   output logic            active_o,
   output logic            ext_o
);
   // Comparator outputs are high while the rail is inside its limit
   assign uv_ok_o  = ~uv_fail_i;
   assign ov_ok_o  = ~ov_fail_i;
   assign warn_o   = hot_i;
   assign active_o = on_i;
   assign ext_o    = ext_i;
endmodule : rail_status_model
`default_nettype wire

// file: testbench/power_good_clock_ctrl_chk.sv
// Assertion checker for the power-good and clock-source control block
`timescale 1ns/1ns
`default_nettype none
module power_good_clock_ctrl_chk
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_en_i,
   input wire logic       rd_en_i,
   input wire logic [7:0] rdata_o,
   input wire logic       ext_clock_present_i,
   input wire logic       power_good_out_o,
   input wire logic       power_good_oe_o,
   input wire logic       pll_enable_o,
   input wire logic       use_ext_clock_o,
   input wire logic [4:0] ext_clock_freq_code_o,
   input wire logic [5:0] ext_clock_mhz_o,
   input wire logic       otp_reload_o,
   input wire logic       i2c_reset_o,
   input wire logic       regulators_disable_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   soft_pulse_a: assert property (
      otp_reload_o |-> i2c_reset_o && regulators_disable_o)
      else $error("soft reset side pulses disagree");
   pulse_once_a: assert property (
      otp_reload_o |=> !otp_reload_o)
      else $error("soft reset pulse too long");
   soft_start_a: assert property (
      wr_en_i && addr_i == 8'h18 && wdata_i[0] && !otp_reload_o |=> otp_reload_o)
      else $error("soft reset not started");
   mhz_code_a: assert property (
      ext_clock_mhz_o == {1'b0, ext_clock_freq_code_o} + 6'h01)
      else $error("frequency not code plus one");
   ext_pll_a: assert property (
      use_ext_clock_o |-> pll_enable_o)
      else $error("external clock used without pll");
   ext_gone_a: assert property (
      !ext_clock_present_i [*3] |-> !use_ext_clock_o)
      else $error("absent external clock still used");
   od_release_a: assert property (
      power_good_out_o |-> power_good_oe_o)
      else $error("pin high while not driven");
   fault_rsv_a: assert property (
      rd_en_i && addr_i == 8'h17 |=> rdata_o[7:4] == 4'h0)
      else $error("fault register upper bits set");
   pll_on_a: assert property (
      wr_en_i && addr_i == 8'h14 && wdata_i[6] && !otp_reload_o |-> ##2 pll_enable_o)
      else $error("pll not enabled");
   pll_off_a: assert property (
      wr_en_i && addr_i == 8'h14 && !wdata_i[6] && !otp_reload_o
      |-> ##2 !pll_enable_o && !use_ext_clock_o)
      else $error("pll not disabled");
endmodule : power_good_clock_ctrl_chk

bind power_good_clock_ctrl power_good_clock_ctrl_chk power_good_clock_ctrl_chk_i
(
   .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o),
   .ext_clock_present_i(ext_clock_present_i), .power_good_out_o(power_good_out_o),
   .power_good_oe_o(power_good_oe_o), .pll_enable_o(pll_enable_o),
   .use_ext_clock_o(use_ext_clock_o), .ext_clock_freq_code_o(ext_clock_freq_code_o),
   .ext_clock_mhz_o(ext_clock_mhz_o), .otp_reload_o(otp_reload_o),
   .i2c_reset_o(i2c_reset_o), .regulators_disable_o(regulators_disable_o)
);
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the power-good and clock-source control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic       wr_en_i = 1'b0;
   logic       rd_en_i = 1'b0;
   logic [3:0] uv_fail = 4'h0;
   logic [3:0] ov_fail = 4'h0;
   logic       hot = 1'b0;
   logic       on = 1'b1;
   logic       ext = 1'b0;
   logic [7:0] rdata_o;
   logic [3:0] uv_ok, ov_ok;
   logic       warn, act, ext_p, pg_out, pg_oe, pll_en, use_ext, otp, i2c_rst, reg_dis;
   logic [4:0] code;
   logic [5:0] mhz;
   int         fails = 0;
   int         n_checks = 0;

   always #2 clk_i = ~clk_i;

   rail_status_model rail_status_model_i
   (
      .uv_fail_i(uv_fail), .ov_fail_i(ov_fail), .hot_i(hot), .on_i(on), .ext_i(ext),
      .uv_ok_o(uv_ok), .ov_ok_o(ov_ok), .warn_o(warn), .active_o(act), .ext_o(ext_p)
   );

   power_good_clock_ctrl power_good_clock_ctrl_i
   (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rdata_o(rdata_o),
      .rail_uv_ok_i(uv_ok), .rail_ov_ok_i(ov_ok), .thermal_warning_i(warn),
      .regulators_active_i(act), .ext_clock_present_i(ext_p),
      .power_good_out_o(pg_out), .power_good_oe_o(pg_oe), .pll_enable_o(pll_en),
      .use_ext_clock_o(use_ext), .ext_clock_freq_code_o(code), .ext_clock_mhz_o(mhz),
      .otp_reload_o(otp), .i2c_reset_o(i2c_rst), .regulators_disable_o(reg_dis)
   );

   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e)
      begin
         fails++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_i  = a;
      wdata_i = d;
      wr_en_i = 1'b1;
      @(negedge clk_i);
      wr_en_i = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(negedge clk_i);
      addr_i  = a;
      rd_en_i = 1'b1;
      @(negedge clk_i);
      rd_en_i = 1'b0;
      cmp(rdata_o & m, e);
   endtask : rd

   // Pin settles one cycle after its cause; extra margin for the register write
   task automatic pin(input logic [1:0] e);
      repeat (3) @(negedge clk_i);
      cmp({6'h00, pg_out, pg_oe}, {6'h00, e});
   endtask : pin

   task automatic final_report;
      if (fails == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report

   task automatic t_defaults;
      rd(8'h14, 8'hff, 8'h01);
      rd(8'h15, 8'hff, 8'h70);
      rd(8'h16, 8'hff, 8'h01);
      rd(8'h17, 8'hff, 8'h00);
      rd(8'h18, 8'hff, 8'h00);
      wr(8'h20, 8'h5a);
      rd(8'h20, 8'hff, 8'h00);
      cmp({pll_en, 1'b0, mhz}, 8'h02);
   endtask : t_defaults

   task automatic t_clock;
      wr(8'h14, 8'h57);
      ext = 1'b1;
      repeat (4) @(negedge clk_i);
      cmp({pll_en, use_ext, mhz}, 8'hd8);
      cmp({3'h0, code}, 8'h17);
      rd(8'h19, 8'h10, 8'h10);
      wr(8'h19, 8'h10);
      rd(8'h19, 8'h10, 8'h00);
      ext = 1'b0;
      repeat (4) @(negedge clk_i);
      cmp({7'h00, use_ext}, 8'h00);
      rd(8'h19, 8'h10, 8'h10);
      wr(8'h19, 8'h10);
      wr(8'h14, 8'h01);
      ext = 1'b1;
      repeat (4) @(negedge clk_i);
      cmp({6'h00, pll_en, use_ext}, 8'h00);
      rd(8'h19, 8'h10, 8'h00);
   endtask : t_clock

   task automatic t_power_good_out;
      pin(2'b00);
      wr(8'h15, 8'h01);
      pin(2'b11);
      wr(8'h15, 8'h81);
      pin(2'b01);
      wr(8'h15, 8'h01);
      ov_fail = 4'h1;
      pin(2'b11);
      wr(8'h15, 8'h11);
      pin(2'b01);
      rd(8'h19, 8'h80, 8'h80);
      rd(8'h17, 8'hff, 8'h01);
      wr(8'h15, 8'h10);
      wr(8'h17, 8'h01);
      rd(8'h17, 8'hff, 8'h01);
      ov_fail = 4'h0;
      wr(8'h17, 8'h00);
      rd(8'h17, 8'hff, 8'h01);
      wr(8'h17, 8'h01);
      rd(8'h17, 8'hff, 8'h00);
      wr(8'h15, 8'h24);
      ov_fail = 4'h4;
      pin(2'b01);
      wr(8'h15, 8'h04);
      pin(2'b11);
      wr(8'h16, 8'h03);
      pin(2'b01);
      wr(8'h17, 8'h04);
      pin(2'b11);
      wr(8'h16, 8'h05);
      hot = 1'b1;
      pin(2'b01);
      wr(8'h16, 8'h01);
      pin(2'b11);
      wr(8'h16, 8'h00);
      on = 1'b0;
      pin(2'b01);
      on = 1'b1;
      pin(2'b11);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h15, 8'h01 << i);
         uv_fail = 4'h1 << i;
         pin(2'b01);
         uv_fail = ~(4'h1 << i);
         pin(2'b11);
      end
      uv_fail = 4'h0;
   endtask : t_power_good_out

   task automatic t_soft;
      wr(8'h15, 8'h8f);
      wr(8'h18, 8'h01);
      cmp({5'h00, otp, i2c_rst, reg_dis}, 8'h07);
      rd(8'h15, 8'hff, 8'h70);
      rd(8'h18, 8'hff, 8'h00);
      rd(8'h1a, 8'h01, 8'h01);
      wr(8'h1a, 8'h01);
      rd(8'h1a, 8'h01, 8'h00);
   endtask : t_soft

   initial
   begin
      repeat (8) @(negedge clk_i);
      rst_i = 1'b0;
      t_defaults();
      t_clock();
      t_power_good_out();
      t_soft();
      final_report();
   end

   // Whole run is under two hundred cycles; this cuts a hang short
   initial
   begin
      #20000;
      fails++;
      final_report();
   end
endmodule : testbench
`default_nettype wire
